// file: src/clock_and_low_power_control.sv
// Clock generation and low-power control with an AHB-Lite register slave.
// Assumes clk_i runs at four times the reference input rate, so every
// device clock rate is a whole division of clk_i; all clocks leave as
// one-cycle enable pulses for gating downstream logic.
//
// Notes on behaviour
// - Three-bit writable PLL ratio select field
// - Ratio in bits 11:9 picks output multiple
// - Ratio resets to all ones, half rate
// - Idle stops CPU clocks, output clock runs except in halt and relock until the PLL settles
// - Reset or interrupt ends CPU idle
// - Separate gated CPU and system domains
// - Bits 13:12 choose low-power mode on idle
// - Second mode stops both domains, rest on
// - First mode wakes on peripheral or external interrupts, reset, protect
// - Second mode wakes on wakeup or external interrupts, reset, protect
// - Halt stops oscillator, PLL, watchdog; protect wakes
// - Peripheral clock enables reset to off
// - Running normally keeps every clock on
// - Watchdog clock is output clock over 512
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

module clock_and_low_power_control #(
  parameter int LOCK_CYCLES = clock_lp_pkg::PLL_LOCK_CYCLES,
  parameter int WD_DIV      = clock_lp_pkg::WATCHDOG_DIV
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // CPU and wake sources
  input  wire logic        idle_exec_i,
  input  wire logic        periph_irq_i,
  input  wire logic        ext_irq_i,
  input  wire logic        wakeup_irq_i,
  input  wire logic        power_drive_protect_input_n_i,
  // Clock enables and power controls
  output logic             device_output_clock_o,
  output logic             cpu_clk_en_o,
  output logic             sys_clk_en_o,
  output logic             watchdog_tick_clock_o,
  output logic             adc_clk_en_o,
  output logic             sci_clk_en_o,
  output logic             event_manager_unit_clk_en_o,
  output logic             osc_enable_o,
  output logic             pll_enable_o,
  output logic             flash_power_o,
  output logic             cpu_idle_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  clock_lp_pkg::ctrl_t     ctrl_q;
  clock_lp_pkg::lp_state_t state_q;
  logic                    wr_pend_q;
  logic                    rd_pend_q;
  logic [11:0]             addr_q;
  logic [2:0]              active_ratio_q;
  logic [2:0]              lock_target_q;
  logic [15:0]             lock_cnt_q;
  logic [2:0]              div_cnt_q;
  logic [8:0]              wd_cnt_q;
  logic                    addr_phase;
  logic                    pll_locked;
  logic                    pll_run;
  logic                    dev_pulse;
  logic                    protect_on;
  logic                    cpu_dom_on;
  logic                    sys_dom_on;
  logic [31:0]             ctrl_word;
  logic [31:0]             stat_word;
  logic [31:0]             rd_word;

  localparam logic [15:0] LOCK_LOAD = 16'(LOCK_CYCLES);
  localparam logic [8:0]  WD_LAST   = 9'(WD_DIV - 1);

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  // Transfer taken only when this slave and the bus are both ready
  assign addr_phase = hsel_i && htrans_i[1] && hready_i && hreadyout_o;

  // Address phase capture; reads get one wait state so that a read
  // right behind a write sees the freshly written value
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end else begin
      wr_pend_q <= addr_phase && hwrite_i;
      rd_pend_q <= addr_phase && !hwrite_i;
      if (addr_phase) begin
        addr_q <= haddr_i[11:0];
      end
    end
  end

  // Wait state on reads only; response is always OKAY
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= 32'h0000_0000;
    end else begin
      hresp_o <= 1'b0;
      if (addr_phase && !hwrite_i) begin
        hreadyout_o <= 1'b0;
      end else if (rd_pend_q) begin
        hreadyout_o <= 1'b1;
        hrdata_o    <= rd_word;
      end
    end
  end

  // Read images; bits not listed read as zero
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[clock_lp_pkg::SLEEP_SEL_LSB +: 2] = ctrl_q.sleep_sel;
    ctrl_word[clock_lp_pkg::RATIO_LSB +: 3]     = ctrl_q.ratio;
    ctrl_word[clock_lp_pkg::ADC_EN_BIT]         = ctrl_q.adc_en;
    ctrl_word[clock_lp_pkg::SCI_EN_BIT]         = ctrl_q.sci_en;
    ctrl_word[clock_lp_pkg::EVM_EN_BIT]         = ctrl_q.evm_en;
    ctrl_word[clock_lp_pkg::FLASH_ON_BIT]       = ctrl_q.flash_on;
    stat_word = 32'h0000_0000;
    stat_word[clock_lp_pkg::STAT_STATE_LSB +: 3] = state_q;
    stat_word[clock_lp_pkg::STAT_LOCKED_BIT]     = pll_locked;
    stat_word[clock_lp_pkg::STAT_RATIO_LSB +: 3] = active_ratio_q;
    case (addr_q)
      clock_lp_pkg::SYS_CTRL_ONE_OFS: rd_word = ctrl_word;
      clock_lp_pkg::CLK_STATUS_OFS:   rd_word = stat_word;
      default:                        rd_word = 32'h0000_0000;
    endcase
  end

  // Control register; unmapped and status writes are dropped
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_q.sleep_sel <= clock_lp_pkg::SLEEP_RESET;
      ctrl_q.ratio     <= clock_lp_pkg::RATIO_RESET;
      ctrl_q.adc_en    <= clock_lp_pkg::PERIPH_RESET;
      ctrl_q.sci_en    <= clock_lp_pkg::PERIPH_RESET;
      ctrl_q.evm_en    <= clock_lp_pkg::PERIPH_RESET;
      ctrl_q.flash_on  <= clock_lp_pkg::FLASH_ON_RESET;
    end else if (wr_pend_q &&
                 addr_q == clock_lp_pkg::SYS_CTRL_ONE_OFS) begin
      ctrl_q.sleep_sel <= hwdata_i[clock_lp_pkg::SLEEP_SEL_LSB +: 2];
      ctrl_q.ratio     <= hwdata_i[clock_lp_pkg::RATIO_LSB +: 3];
      ctrl_q.adc_en    <= hwdata_i[clock_lp_pkg::ADC_EN_BIT];
      ctrl_q.sci_en    <= hwdata_i[clock_lp_pkg::SCI_EN_BIT];
      ctrl_q.evm_en    <= hwdata_i[clock_lp_pkg::EVM_EN_BIT];
      // Flash is never cut by hardware; software must clear this first
      ctrl_q.flash_on  <= hwdata_i[clock_lp_pkg::FLASH_ON_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Low-power sequencer
  // ---------------------------------------------------------------
  assign protect_on = !power_drive_protect_input_n_i;

  // Reset wakes every mode through reset_i itself
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= clock_lp_pkg::ST_RUN;
    end else begin
      case (state_q)
        clock_lp_pkg::ST_RUN: begin
          if (idle_exec_i) begin
            if (ctrl_q.sleep_sel == clock_lp_pkg::SLEEP_CPU_ONLY) begin
              state_q <= clock_lp_pkg::ST_CPU_STOP;
            end else if (ctrl_q.sleep_sel ==
                         clock_lp_pkg::SLEEP_ALL_DOM) begin
              state_q <= clock_lp_pkg::ST_ALL_STOP;
            end else begin
              state_q <= clock_lp_pkg::ST_HALT;
            end
          end
        end
        clock_lp_pkg::ST_CPU_STOP: begin
          if (periph_irq_i || ext_irq_i || protect_on) begin
            state_q <= clock_lp_pkg::ST_RUN;
          end
        end
        clock_lp_pkg::ST_ALL_STOP: begin
          // Ordinary peripheral interrupts cannot reach a stopped domain
          if (wakeup_irq_i || ext_irq_i || protect_on) begin
            state_q <= clock_lp_pkg::ST_RUN;
          end
        end
        clock_lp_pkg::ST_HALT: begin
          if (protect_on) begin
            state_q <= clock_lp_pkg::ST_RELOCK;
          end
        end
        clock_lp_pkg::ST_RELOCK: begin
          // Oscillator and PLL restart; CPU waits for a settled clock
          if (pll_locked) begin
            state_q <= clock_lp_pkg::ST_RUN;
          end
        end
        default: begin
          state_q <= clock_lp_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Domain gating per mode; normal running keeps everything on
  assign cpu_dom_on = (state_q == clock_lp_pkg::ST_RUN);
  assign sys_dom_on = (state_q == clock_lp_pkg::ST_RUN) ||
                      (state_q == clock_lp_pkg::ST_CPU_STOP);
  assign pll_run    = (state_q != clock_lp_pkg::ST_HALT);

  // ---------------------------------------------------------------
  // PLL model and ratio switching
  // ---------------------------------------------------------------
  assign pll_locked = (lock_cnt_q == 16'h0000);

  // A new target, or a restart after halt, reloads the settle timer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lock_target_q <= clock_lp_pkg::RATIO_RESET;
      lock_cnt_q    <= 16'h0000;
    end else if (!pll_run) begin
      lock_cnt_q    <= LOCK_LOAD;
    end else if (ctrl_q.ratio != lock_target_q) begin
      lock_target_q <= ctrl_q.ratio;
      lock_cnt_q    <= LOCK_LOAD;
    end else if (!pll_locked) begin
      lock_cnt_q    <= lock_cnt_q - 16'h0001;
    end
  end

  // Period is ratio plus one clk_i cycles: code 0 is four times the
  // reference, code 7 half of it. Old period runs until the settle
  // timer ends, and the new one is taken only at a period boundary,
  // so no short pulse appears during the change.
  assign dev_pulse = pll_run && (div_cnt_q == active_ratio_q) &&
                     (state_q != clock_lp_pkg::ST_RELOCK || pll_locked);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_cnt_q      <= 3'h0;
      active_ratio_q <= clock_lp_pkg::RATIO_RESET;
    end else if (dev_pulse) begin
      div_cnt_q <= 3'h0;
      if (pll_locked) begin
        active_ratio_q <= lock_target_q;
      end
    end else if (pll_run && div_cnt_q != active_ratio_q) begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  // Watchdog tick counts output clock pulses; halt stops it with them
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wd_cnt_q <= 9'h000;
    end else if (dev_pulse) begin
      wd_cnt_q <= (wd_cnt_q == WD_LAST) ? 9'h000 : wd_cnt_q + 9'h001;
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  // Clock enables: one cycle behind the internal pulse
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      device_output_clock_o       <= 1'b0;
      cpu_clk_en_o                <= 1'b0;
      sys_clk_en_o                <= 1'b0;
      watchdog_tick_clock_o       <= 1'b0;
      adc_clk_en_o                <= 1'b0;
      sci_clk_en_o                <= 1'b0;
      event_manager_unit_clk_en_o <= 1'b0;
    end else begin
      device_output_clock_o <= dev_pulse;
      cpu_clk_en_o          <= dev_pulse && cpu_dom_on;
      sys_clk_en_o          <= dev_pulse && sys_dom_on;
      watchdog_tick_clock_o <= dev_pulse &&
                               (wd_cnt_q == WD_LAST);
      adc_clk_en_o          <= dev_pulse && sys_dom_on &&
                               ctrl_q.adc_en;
      sci_clk_en_o          <= dev_pulse && sys_dom_on &&
                               ctrl_q.sci_en;
      event_manager_unit_clk_en_o <= dev_pulse && sys_dom_on &&
                                     ctrl_q.evm_en;
    end
  end

  // Power controls and idle indication
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      osc_enable_o  <= 1'b1;
      pll_enable_o  <= 1'b1;
      flash_power_o <= clock_lp_pkg::FLASH_ON_RESET;
      cpu_idle_o    <= 1'b0;
    end else begin
      osc_enable_o  <= pll_run;
      pll_enable_o  <= pll_run;
      flash_power_o <= ctrl_q.flash_on;
      cpu_idle_o    <= !cpu_dom_on;
    end
  end

endmodule : clock_and_low_power_control

// file: src/clock_lp_pkg.sv
// Package for the clock and low-power control block: register map,
// field layout, reset values, low-power states and timing constants.
// Assumes a 32-bit AHB-Lite register bus and a 100 MHz system clock.
package clock_lp_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] SYS_CTRL_ONE_OFS = 12'h000;
  localparam logic [11:0] CLK_STATUS_OFS   = 12'h004;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int SLEEP_SEL_LSB = 12;
  localparam int RATIO_LSB     = 9;
  localparam int ADC_EN_BIT    = 7;
  localparam int SCI_EN_BIT    = 6;
  localparam int EVM_EN_BIT    = 2;
  localparam int FLASH_ON_BIT  = 0;

  // Reset values: ratio all ones, peripheral clocks off, flash on
  localparam logic [2:0] RATIO_RESET    = 3'h7;
  localparam logic [1:0] SLEEP_RESET    = 2'h0;
  localparam logic       PERIPH_RESET   = 1'b0;
  localparam logic       FLASH_ON_RESET = 1'b1;

  // Sleep select values
  localparam logic [1:0] SLEEP_CPU_ONLY = 2'h0;
  localparam logic [1:0] SLEEP_ALL_DOM  = 2'h1;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_LOCKED_BIT = 4;
  localparam int STAT_RATIO_LSB  = 8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int PLL_LOCK_TIME_NS = 1000;
  localparam int PLL_LOCK_CYCLES  =
    (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WATCHDOG_DIV     = 512;

  // Software visible control fields
  typedef struct packed {
    logic [1:0] sleep_sel;
    logic [2:0] ratio;
    logic       adc_en;
    logic       sci_en;
    logic       evm_en;
    logic       flash_on;
  } ctrl_t;

  // Low-power sequencer states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_CPU_STOP,
    ST_ALL_STOP,
    ST_HALT,
    ST_RELOCK
  } lp_state_t;

endpackage : clock_lp_pkg

// file: testbench/clock_lp_properties.sv
// Checker for the clock and low-power block, bound to its top module.
// Sees only ports; the bench keeps bus and wake traffic legal.
`timescale 1ns/1ps
module clock_lp_properties #(
  parameter int LOCK_CYCLES = 100
) (
  // Clock, reset and bus
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic       hwrite_i,
  input wire logic       hready_i,
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  // Wake sources
  input wire logic       ext_irq_i,
  input wire logic       power_drive_protect_input_n_i,
  // Clock enables and power
  input wire logic       device_output_clock_o,
  input wire logic       cpu_clk_en_o,
  input wire logic       sys_clk_en_o,
  input wire logic       watchdog_tick_clock_o,
  input wire logic       adc_clk_en_o,
  input wire logic       sci_clk_en_o,
  input wire logic       event_manager_unit_clk_en_o,
  input wire logic       osc_enable_o,
  input wire logic       pll_enable_o,
  input wire logic       cpu_idle_o
);
  // Relock may use the whole settle time before the CPU runs
  localparam int WAKE_MAX = LOCK_CYCLES + 6;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  sequence rd_taken;
    hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  endsequence
  sequence wr_taken;
    hsel_i && htrans_i[1] && hready_i && hwrite_i;
  endsequence
  a_read_one_wait: assert property (
    rd_taken |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (wr_taken |=> hreadyout_o)
    else $error("write was stalled");
  a_resp_okay: assert property (!hresp_o)
    else $error("response not okay");
  // ------------------------------------------------------------
  // Clock domains and low power
  // ------------------------------------------------------------
  a_idle_stops_cpu: assert property (cpu_idle_o |-> !cpu_clk_en_o)
    else $error("cpu clock runs in idle");
  a_run_cpu_clock: assert property (
    !cpu_idle_o && !$past(cpu_idle_o) |->
      cpu_clk_en_o == device_output_clock_o)
    else $error("cpu clock differs from output clock");
  a_periph_gated: assert property (
    adc_clk_en_o || sci_clk_en_o || event_manager_unit_clk_en_o
      |-> sys_clk_en_o)
    else $error("peripheral clock without system clock");
  a_run_osc_on: assert property (
    !cpu_idle_o |-> osc_enable_o && pll_enable_o)
    else $error("oscillator off while running");
  a_halt_all_off: assert property (!osc_enable_o |-> !pll_enable_o &&
    !sys_clk_en_o && !cpu_clk_en_o && !watchdog_tick_clock_o)
    else $error("clock runs in halt");
  a_halt_holds: assert property (
    !osc_enable_o && power_drive_protect_input_n_i &&
      $past(power_drive_protect_input_n_i) &&
      $past(power_drive_protect_input_n_i, 2) |=> !osc_enable_o)
    else $error("halt left without protect");
  a_ext_wakes: assert property (
    cpu_idle_o && osc_enable_o && ext_irq_i |->
      ##[1:WAKE_MAX] !cpu_idle_o)
    else $error("external interrupt did not wake");
  a_protect_wakes: assert property (
    cpu_idle_o && !power_drive_protect_input_n_i |->
      ##[1:WAKE_MAX] !cpu_idle_o)
    else $error("protect input did not wake");
endmodule : clock_lp_properties

bind clock_and_low_power_control clock_lp_properties #(
  .LOCK_CYCLES(LOCK_CYCLES)) u_props (.*);

// file: testbench/cpu_wake_model.sv
// Model of the CPU core and its wake sources at the block's far side.
// Assumes bench commands change just after a rising edge.
`timescale 1ns/1ps
module cpu_wake_model (
  // Clock, reset and bench commands {protect, wakeup, ext, periph}
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       go_idle_i,
  input  wire logic [3:0] wake_vec_i,
  input  wire logic       cpu_idle_i,
  // Lines into the block
  output logic            idle_exec_o,
  output logic            periph_irq_o,
  output logic            ext_irq_o,
  output logic            wakeup_irq_o,
  output logic            protect_n_o
);
  logic go_q;
  // One idle instruction pulse per request edge
  always_ff @(posedge clk_i) begin
    go_q        <= go_idle_i;
    idle_exec_o <= go_idle_i && !go_q && !reset_i;
  end
  // Requests stand until the core runs, as an acknowledged request
  always_ff @(posedge clk_i) begin
    if (reset_i || !cpu_idle_i) begin
      {protect_n_o, wakeup_irq_o, ext_irq_o, periph_irq_o} <= 4'h8;
    end else begin
      {wakeup_irq_o, ext_irq_o, periph_irq_o} <= wake_vec_i[2:0];
      protect_n_o <= !wake_vec_i[3];
    end
  end
endmodule : cpu_wake_model

// file: testbench/test_clock_and_low_power_control.sv
// Self-checking bench for the clock and low-power block.
// Assumes the checker binds itself and the wake model plays the CPU.
`timescale 1ns/1ps
module test_clock_and_low_power_control;
  localparam int          LOCK = 40;
  localparam int          WDD  = 8;
  localparam logic [31:0] MASK = 32'h00003ec5;
  localparam logic [11:0] CTRL = clock_lp_pkg::SYS_CTRL_ONE_OFS;
  localparam logic [11:0] STAT = clock_lp_pkg::CLK_STATUS_OFS;
  logic        clk_i = 1'b0, reset_i = 1'b1, hsel_i = 1'b0;
  logic        hwrite_i = 1'b0, go_idle = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = 3'h2;
  logic [3:0]  wake_vec = 4'h0;
  logic        hready_i, hreadyout_o, hresp_o, idle_exec_i, cpu_idle_o;
  logic        periph_irq_i, ext_irq_i, wakeup_irq_i;
  logic        power_drive_protect_input_n_i, device_output_clock_o;
  logic        cpu_clk_en_o, sys_clk_en_o, watchdog_tick_clock_o;
  logic        adc_clk_en_o, sci_clk_en_o, event_manager_unit_clk_en_o;
  logic        osc_enable_o, pll_enable_o, flash_power_o;
  logic [3:0]  bad [4] = '{4'h4, 4'h1, 4'h2, 4'h7};
  logic [3:0]  good [4] = '{4'h3, 4'h4, 4'h8, 4'h8};
  int          mismatches = 0, n_tests = 0, cycles = 0, seed = 32'h0f38;
  assign hready_i = hreadyout_o;
  always #5 clk_i = ~clk_i;
  // ------------------------------------------------------------
  // Design and far side
  // ------------------------------------------------------------
  clock_and_low_power_control #(.LOCK_CYCLES(LOCK), .WD_DIV(WDD)) dut_u (
    .clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
    .idle_exec_i, .periph_irq_i, .ext_irq_i, .wakeup_irq_i,
    .power_drive_protect_input_n_i, .device_output_clock_o, .cpu_clk_en_o,
    .sys_clk_en_o, .watchdog_tick_clock_o, .adc_clk_en_o, .sci_clk_en_o,
    .event_manager_unit_clk_en_o, .osc_enable_o, .pll_enable_o,
    .flash_power_o, .cpu_idle_o);
  cpu_wake_model cpu_u (.clk_i, .reset_i, .go_idle_i(go_idle),
    .wake_vec_i(wake_vec), .cpu_idle_i(cpu_idle_o),
    .idle_exec_o(idle_exec_i), .periph_irq_o(periph_irq_i),
    .ext_irq_o(ext_irq_i), .wakeup_irq_o(wakeup_irq_i),
    .protect_n_o(power_drive_protect_input_n_i));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic int per(input logic [2:0] r, input int k);
    return k * (r + 1);
  endfunction : per
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // Holds each phase until hready is sampled high
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    {hsel_i, htrans_i, hwrite_i, haddr_i} <= {1'b1, 2'h2, wr, 20'h0, a};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    {hsel_i, htrans_i, hwdata_i} <= {1'b0, 2'h0, wd};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : bus
  // Cycles until the picked output is next seen high
  task automatic gap(input int s, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((s == 0 ? device_output_clock_o : s == 1 ?
      watchdog_tick_clock_o : !cpu_idle_o) !== 1'b1 && n < 3000);
  endtask : gap
  task automatic wait_lock(input logic [2:0] r);
    logic [31:0] s;
    int k;
    k = 0;
    do begin
      bus(1'b0, STAT, 32'h0, s);
      k++;
    // Lock shows before the new ratio is taken at a period boundary
    end while ((s[4] !== 1'b1 || s[10:8] !== r) && k < 50);
    check("status", s, {21'h0, r, 8'h10});
  endtask : wait_lock
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Cuts a hang short well above the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d, x;
    logic [2:0] prev;
    int n, ns, nc, no;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(1'b0, CTRL, 32'h0, x);
    check("ctrl reset", x, 32'h00000e01);
    bus(1'b0, 12'h008, 32'h0, x);
    check("unmapped", x, 32'h0);
    bus(1'b1, STAT, 32'hffffffff, x);
    wait_lock(3'h7);
    prev = 3'h7;
    // Every ratio, with random peripheral enables
    for (int r = 0; r < 8; r++) begin
      d = ($random(seed) & 32'h000000c4) | (r << 9) | 32'h1;
      bus(1'b1, CTRL, d, x);
      gap(0, n);
      gap(0, n);
      check("old period", n, per(prev, 1));
      bus(1'b0, CTRL, 32'h0, x);
      check("ctrl", x, d & MASK);
      wait_lock(3'(r));
      check("flash", flash_power_o, d[0]);
      gap(0, n);
      gap(0, n);
      gap(0, n);
      check("new period", n, per(3'(r), 1));
      gap(1, n);
      gap(1, n);
      check("wd period", n, per(3'(r), WDD));
      // Peripheral clocks follow their random enable bits
      {ns, nc, no} = '0;
      repeat (16) begin
        @(posedge clk_i);
        ns += (adc_clk_en_o === 1'b1);
        nc += (sci_clk_en_o === 1'b1);
        no += (event_manager_unit_clk_en_o === 1'b1);
      end
      check("adc clk", ns > 0, d[7]);
      check("sci clk", nc > 0, d[6]);
      check("evm clk", no > 0, d[2]);
      prev = 3'(r);
    end
    // Each sleep select; flash is cut by software before halt
    for (int m = 0; m < 4; m++) begin
      d = (m << 12) | 32'h00000680 | (m < 2);
      bus(1'b1, CTRL, d, x);
      wait_lock(3'h3);
      check("flash", flash_power_o, d[0]);
      go_idle <= 1'b1;
      repeat (4) @(posedge clk_i);
      go_idle <= 1'b0;
      check("idle", cpu_idle_o, 1'b1);
      {ns, nc, no} = '0;
      wake_vec <= bad[m];
      repeat (24) begin
        @(posedge clk_i);
        ns += (sys_clk_en_o === 1'b1);
        nc += (cpu_clk_en_o === 1'b1);
        no += (osc_enable_o === 1'b1);
      end
      check("cpu pulses", nc, 0);
      check("sys runs", ns > 0, m == 0);
      check("osc on", no > 0, m < 2);
      check("still idle", cpu_idle_o, 1'b1);
      wake_vec <= bad[m] | good[m];
      gap(2, n);
      check("woke", n < LOCK + 12, 1'b1);
      wake_vec <= 4'h0;
    end
    // Reset alone ends halt and brings back every reset value
    bus(1'b1, CTRL, 32'h00002e00, x);
    go_idle <= 1'b1;
    repeat (4) @(posedge clk_i);
    go_idle <= 1'b0;
    check("halted", osc_enable_o, 1'b0);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    check("reset wake", {cpu_idle_o, osc_enable_o}, 2'b01);
    bus(1'b0, CTRL, 32'h0, x);
    check("ctrl after reset", x, 32'h00000e01);
    tally_and_finish();
  end
endmodule : test_clock_and_low_power_control
